// [shared/lcd_pkg.sv]
// Package for the loop-code detect and single error insert block.
// Assumes one 250 MHz system clock; all other rates are enables.
package lcd_pkg;
	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] LCD_OFF_LOOP_CTRL   = 8'h00;
	localparam logic [7:0] LCD_OFF_ERR_CTRL    = 8'h04;
	localparam logic [7:0] LCD_OFF_STATUS      = 8'h08;
	localparam logic [7:0] LCD_OFF_INT_STATUS  = 8'h0c;
	localparam logic [7:0] LCD_OFF_INT_MASK    = 8'h10;
	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int LCD_SEL_LSB      = 6;
	localparam int LCD_ERR_BIT      = 1;
	localparam int LCD_TEST_LSB     = 2;
	localparam int LCD_DET_BIT      = 3;
	localparam int LCD_LOOPBACK_BIT = 0;
	localparam logic [7:0] LCD_CTRL_RST = 8'h00;
	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] LCD_SEL_OFF  = 2'h0;
	localparam logic [1:0] LCD_SEL_UP   = 2'h1;
	localparam logic [1:0] LCD_SEL_DOWN = 2'h2;
	localparam logic [1:0] LCD_SEL_AUTO = 2'h3;
	localparam logic [2:0] LCD_TEST_QRSS = 3'h4;
	localparam logic [4:0] LCD_UP_PAT   = 5'h01;
	localparam logic [2:0] LCD_DOWN_PAT = 3'h1;
	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int LCD_QUAL_S   = 5;
	localparam int LCD_CLK_MHZ  = 250;
	localparam int LCD_TICK_US  = 1000;
	localparam int LCD_TICK_CYC = LCD_TICK_US * LCD_CLK_MHZ;
	localparam int LCD_QUAL_TICKS = LCD_QUAL_S * 1000000 / LCD_TICK_US;
endpackage : lcd_pkg

// [logic/lcd_pattern_match.sv]
// Pattern matcher with persistence counter for the receive data.
// Assumes rx_bit/rx_valid are already in the aclk domain.
`timescale 1ns/1ps
module lcd_pattern_match
	import lcd_pkg::*;
#(
	parameter int TICK_CYC   = LCD_TICK_CYC,
	parameter int QUAL_TICKS = LCD_QUAL_TICKS
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Control
	input  wire logic [1:0] sel,
	// Receive data
	input  wire logic       rx_bit,
	input  wire logic       rx_valid,
	// Result
	output logic            detected
);
	logic [4:0]  hist_q;
	logic [31:0] tick_q;
	logic [31:0] qual_q;
	logic        det_q;
	logic [1:0]  sel_q;
	wire         is_down = (sel == LCD_SEL_DOWN);
	// Repeating pattern: current 5 or 3 bits equal pattern one period earlier too
	wire up_hit   = {hist_q[3:0], rx_bit} == LCD_UP_PAT;
	wire down_hit = {hist_q[1:0], rx_bit} == LCD_DOWN_PAT;
	logic [3:0]  phase_q;
	logic [3:0]  miss_q;
	wire  [3:0]  period = is_down ? 4'h3 : 4'h5;
	wire         hit    = is_down ? down_hit : up_hit;
	wire         tick   = (tick_q == 32'(TICK_CYC - 1));
	wire         sel_same = (sel == sel_q);
	wire         match  = (miss_q == 4'h0) && (sel != LCD_SEL_OFF) && sel_same;
	// Select seen last cycle; a change restarts the search from scratch
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sel_q <= LCD_SEL_OFF;
		else
			sel_q <= sel;
	end
	// Bits since last hit; pattern may sit at any alignment on the line
	always_ff @(posedge aclk) begin
		if (!aresetn || sel == LCD_SEL_OFF || !sel_same) begin
			hist_q  <= 5'h00;
			phase_q <= 4'h0;
			miss_q  <= 4'h8;
		end else if (rx_valid) begin
			hist_q  <= {hist_q[3:0], rx_bit};
			phase_q <= hit ? 4'h0 : ((phase_q == 4'hf) ? 4'hf : phase_q + 4'h1);
			// Next hit must land exactly one period after the last
			if (hit)
				miss_q <= (phase_q == period - 4'h1) ? 4'h0 : 4'h8;
			else if (phase_q >= period - 4'h1)
				miss_q <= 4'h8;
		end
	end
	// Free-running time base and persistence count; the count restarts on loss of match
	always_ff @(posedge aclk) begin
		if (!aresetn)
			tick_q <= 32'h0;
		else
			tick_q <= tick ? 32'h0 : tick_q + 32'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !match) begin
			qual_q <= 32'h0;
			det_q  <= 1'b0;
		end else if (tick) begin
			if (qual_q > 32'(QUAL_TICKS))
				det_q <= 1'b1;
			else
				qual_q <= qual_q + 32'h1;
		end
	end
	// Masked on a select change so a stale result never reaches loopback
	assign detected = det_q && sel_same;
endmodule : lcd_pattern_match

// [logic/lcd_loop_code.sv]
// Top: AXI4-Lite registers, loop-code detect, loopback and error insert.
// Assumes rx/tx pins asynchronous to aclk; tx clock sampled as data.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Two-bit select: off, loop-up, loop-down, loop-up with auto loopback.
// - Loop-up detection looks for repeating 00001 in receive data.
// - Loop-down looks for repeating 001 lasting over five seconds.
// - Detection sets status bit 3; interrupt only if enable bit 3 set.
// - Auto mode: qualified loop-up sets flag and activates remote loopback.
// - In QRSS test mode a 0-to-1 insert bit flips one transmit bit.
// - Insert bit sampled on rising transmit clock edges, edge found there.
module lcd_loop_code
	import lcd_pkg::*;
#(
	parameter int TICK_CYC   = LCD_TICK_CYC,
	parameter int QUAL_TICKS = LCD_QUAL_TICKS
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Receive line data (pins)
	input  wire logic        rx_data,
	input  wire logic        rx_clk,
	// Transmit path
	input  wire logic        channel_transmit_clock,
	input  wire logic        tx_data_in,
	output logic             tx_data_out,
	// Status outputs
	output logic             remote_loopback,
	output logic             irq
);
	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0] loop_ctrl_q;
	logic [7:0] test_error_insert_control_q;
	logic       loop_code_detected_flag_q;
	logic       loopback_q;
	logic [7:0] int_status_q;
	logic [7:0] int_mask_q;
	logic       aw_q, w_q, bvalid_q, arready_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] rdata_q;
	logic [1:0] bresp_q, rresp_q;
	logic       irq_q, tx_q;
	wire [1:0]  loop_code_detect_select = loop_ctrl_q[LCD_SEL_LSB +: 2];
	wire [2:0]  transmit_test_pattern_select = test_error_insert_control_q[LCD_TEST_LSB +: 3];
	wire        single_error_inject_bit = test_error_insert_control_q[LCD_ERR_BIT];

	// ------------------------------------------------------------------
	// Pin synchronisers: three flops, change taken when 2nd and 3rd agree
	// ------------------------------------------------------------------
	logic [2:0] rxd_s, rxc_s, txc_s, txd_s;
	logic       rxd_f, rxc_f, txc_f, txd_f, rxc_prev, txc_prev, ins_prev_q;
	always_ff @(posedge aclk) begin
		rxd_s <= {rxd_s[1:0], rx_data};
		rxc_s <= {rxc_s[1:0], rx_clk};
		txc_s <= {txc_s[1:0], channel_transmit_clock};
		txd_s <= {txd_s[1:0], tx_data_in};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxd_f <= 1'b0;
			rxc_f <= 1'b0;
			txc_f <= 1'b0;
			txd_f <= 1'b0;
		end else begin
			if (rxd_s[1] == rxd_s[2]) rxd_f <= rxd_s[2];
			if (rxc_s[1] == rxc_s[2]) rxc_f <= rxc_s[2];
			if (txc_s[1] == txc_s[2]) txc_f <= txc_s[2];
			if (txd_s[1] == txd_s[2]) txd_f <= txd_s[2];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxc_prev <= 1'b0;
			txc_prev <= 1'b0;
		end else begin
			rxc_prev <= rxc_f;
			txc_prev <= txc_f;
		end
	end
	wire rx_edge = rxc_f && !rxc_prev;
	wire tx_edge = txc_f && !txc_prev;

	// ------------------------------------------------------------------
	// Loop-code detection
	// ------------------------------------------------------------------
	logic det;
	lcd_pattern_match #(
		.TICK_CYC   (TICK_CYC),
		.QUAL_TICKS (QUAL_TICKS)
	) u_match (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sel      (loop_code_detect_select),
		.rx_bit   (rxd_f),
		.rx_valid (rx_edge),
		.detected (det)
	);
	logic det_prev_q;
	wire  det_change = det ^ det_prev_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			det_prev_q                <= 1'b0;
			loop_code_detected_flag_q <= 1'b0;
			loopback_q                <= 1'b0;
		end else begin
			det_prev_q                <= det;
			loop_code_detected_flag_q <= det;
			// Auto mode keeps loopback only while it stays selected
			loopback_q <= (loop_code_detect_select == LCD_SEL_AUTO) &&
				(loopback_q || det);
		end
	end

	// ------------------------------------------------------------------
	// Error insert, edge of insert bit taken on tx clock edges only
	// ------------------------------------------------------------------
	wire ins_rise = tx_edge && single_error_inject_bit && !ins_prev_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ins_prev_q <= 1'b0;
			tx_q       <= 1'b0;
		end else if (tx_edge) begin
			ins_prev_q <= single_error_inject_bit;
			tx_q <= txd_f ^ (ins_rise &&
				transmit_test_pattern_select == LCD_TEST_QRSS);
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take  = s_axi_wvalid && s_axi_wready;
	wire wr_go   = aw_q && w_q && !bvalid_q;
	wire ar_take = s_axi_arvalid && arready_q;
	wire wa_ctrl = (awaddr_q == LCD_OFF_LOOP_CTRL);
	wire wa_err  = (awaddr_q == LCD_OFF_ERR_CTRL);
	wire wa_ist  = (awaddr_q == LCD_OFF_INT_STATUS);
	wire wa_msk  = (awaddr_q == LCD_OFF_INT_MASK);
	wire wa_ok   = wa_ctrl || wa_err || wa_ist || wa_msk || awaddr_q == LCD_OFF_STATUS;
	wire wr_b0   = wr_go && wstrb_q[0];
	wire [7:0] sts_word = {4'h0, loop_code_detected_flag_q, 2'h0, loopback_q};
	// Event sets bit 3; set wins over write-one-to-clear
	wire [7:0] ev_set = {4'h0, det_change, 3'h0};
	wire [7:0] ist_clr = (wr_b0 && wa_ist) ? wdata_q[7:0] : 8'h00;
	logic [7:0] rd_word;
	logic       rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			LCD_OFF_LOOP_CTRL:  rd_word = loop_ctrl_q;
			LCD_OFF_ERR_CTRL:   rd_word = test_error_insert_control_q;
			LCD_OFF_STATUS:     rd_word = sts_word;
			LCD_OFF_INT_STATUS: rd_word = int_status_q;
			LCD_OFF_INT_MASK:   rd_word = int_mask_q;
			default: begin
				rd_word = 8'h00;
				rd_ok   = 1'b0;
			end
		endcase
	end
	// Address and data latches; each released once taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0; w_q <= 1'b0; bvalid_q <= 1'b0; bresp_q <= 2'h0;
			awaddr_q <= 8'h00; wdata_q <= 32'h0; wstrb_q <= 4'h0;
		end else begin
			if (aw_take) begin aw_q <= 1'b1; awaddr_q <= s_axi_awaddr; end
			if (w_take) begin w_q <= 1'b1; wdata_q <= s_axi_wdata; wstrb_q <= s_axi_wstrb; end
			if (wr_go) begin
				aw_q <= 1'b0; w_q <= 1'b0; bvalid_q <= 1'b1;
				bresp_q <= wa_ok ? 2'h0 : 2'h2;
			end else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end
	// Register writes; spare bits kept as storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loop_ctrl_q <= LCD_CTRL_RST;
			test_error_insert_control_q <= LCD_CTRL_RST;
			int_mask_q <= 8'h00;
			int_status_q <= 8'h00;
		end else begin
			if (wr_b0 && wa_ctrl) loop_ctrl_q <= wdata_q[7:0];
			if (wr_b0 && wa_err)  test_error_insert_control_q <= wdata_q[7:0];
			if (wr_b0 && wa_msk)  int_mask_q <= wdata_q[7:0];
			int_status_q <= (int_status_q & ~ist_clr) | ev_set;
		end
	end
	// Read channel and interrupt output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1; rvalid_q <= 1'b0; rdata_q <= 32'h0; rresp_q <= 2'h0;
			irq_q <= 1'b0;
		end else begin
			if (ar_take) begin
				arready_q <= 1'b0; rvalid_q <= 1'b1;
				rdata_q <= {24'h0, rd_word}; rresp_q <= rd_ok ? 2'h0 : 2'h2;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0; arready_q <= 1'b1;
			end
			irq_q <= |(int_status_q & int_mask_q);
		end
	end

	assign s_axi_awready   = !aw_q;
	assign s_axi_wready    = !w_q;
	assign s_axi_bvalid    = bvalid_q;
	assign s_axi_bresp     = bresp_q;
	assign s_axi_arready   = arready_q;
	assign s_axi_rvalid    = rvalid_q;
	assign s_axi_rdata     = rdata_q;
	assign s_axi_rresp     = rresp_q;
	assign tx_data_out     = tx_q;
	assign remote_loopback = loopback_q;
	assign irq             = irq_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	AST_IRQ_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
		(int_status_q[LCD_DET_BIT] && int_mask_q[LCD_DET_BIT]) |=> irq)
		else $error("irq missing for enabled detect");
	AST_IRQ_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
		(int_status_q & int_mask_q) == 8'h00 |=> !irq)
		else $error("irq without enabled status");
	AST_LOOPBACK: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(remote_loopback) |-> $past(det) && $past(loop_code_detect_select) == LCD_SEL_AUTO)
		else $error("loopback without auto detect");
	AST_FLAG_FOLLOWS: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(det) |=> loop_code_detected_flag_q)
		else $error("detect flag not set");
	AST_OFF_NO_DET: assert property (@(posedge aclk) disable iff (!aresetn)
		loop_code_detect_select == LCD_SEL_OFF |=> !det)
		else $error("detect while disabled");
	AST_ERR_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
		(ins_rise && transmit_test_pattern_select == LCD_TEST_QRSS) |=>
		tx_data_out != $past(txd_f))
		else $error("error insert not applied");
	AST_TX_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
		(tx_edge && !ins_rise) |=> tx_data_out == $past(txd_f))
		else $error("transmit bit corrupted without insert");
	AST_INS_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
		!tx_edge |=> $stable(tx_data_out) && $stable(ins_prev_q))
		else $error("insert state moved outside tx edge");
	AST_SPARE: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_b0 && wa_ctrl) |=> loop_ctrl_q == $past(wdata_q[7:0]))
		else $error("control store lost");
endmodule : lcd_loop_code

// [dv/lcd_remote_equip.sv]
// Far-end T1 equipment model that sends loop codes on the line.
// Assumes the device samples rx_data on rising rx_clk.
`timescale 1ns/1ps
module lcd_remote_equip (
	// Pattern: 0 idle ones, 1 loop-up, 2 loop-down
	input  wire logic [1:0] mode,
	// Line
	output logic            rx_clk,
	output logic            rx_data
);
	int unsigned pos;
	// ----
	// Line clock and data
	// ----
	// A T1 line never goes quiet, so the clock runs free
	initial begin
		rx_clk = 1'b0;
		forever #20 rx_clk = ~rx_clk;
	end
	// Data moves on the falling edge, half a bit clear of sampling
	initial begin
		rx_data = 1'b1;
		pos = 0;
		forever begin
			@(negedge rx_clk);
			pos = (pos + 1) % 15;
			case (mode)
				2'h1: rx_data = (pos % 5 == 4);
				2'h2: rx_data = (pos % 3 == 2);
				default: rx_data = 1'b1;
			endcase
		end
	end
endmodule : lcd_remote_equip

// [dv/lcd_loop_code_test.sv]
// Bench for loop-code detect and error insert, acting as bus master.
// Assumes the far-end model drives the receive line.
`timescale 1ns/1ps
module lcd_loop_code_test;
	import lcd_pkg::*;
	// ----
	// Signals
	// ----
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, rx_data, rx_clk, tx_clk;
	logic        tx_in, tx_out, loopback, irq, counting, prev_out;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, seed;
	logic [1:0]  bresp, rresp, mode, div;
	logic [3:0]  wstrb;
	logic [33:0] exp_q[$];
	int          miscompares, comparisons, toggles;
	lcd_loop_code #(.TICK_CYC(4), .QUAL_TICKS(3)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_data(rx_data), .rx_clk(rx_clk),
		.channel_transmit_clock(tx_clk), .tx_data_in(tx_in), .tx_data_out(tx_out),
		.remote_loopback(loopback), .irq(irq));
	lcd_remote_equip i_far (.mode(mode), .rx_clk(rx_clk), .rx_data(rx_data));
	// ----
	// Clock, watchdog, transmit clock and toggle counter
	// ----
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Whole run is about 3000 cycles; this is several times that
	initial begin
		#100000;
		miscompares++;
		conclude();
	end
	// Transmit clock is one sixth of aclk; every tx_out edge is counted while counting is set
	always @(posedge aclk) begin
		div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
		if (div == 2'h2) tx_clk <= ~tx_clk;
		if (counting && tx_out !== prev_out) toggles++;
		prev_out <= tx_out;
	end
	// Bus answers are compared with the oldest note
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1) check("read", {rresp, rdata}, exp_q.pop_front());
		if (bvalid === 1'b1 && bready === 1'b1) check("bresp", {bresp, 32'h0}, exp_q.pop_front());
	end
	// ----
	// Tasks
	// ----
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xorshift = y ^ (y << 5);
	endfunction : xorshift
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask : idle
	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		exp_q.push_back(34'h0);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask : rd
	// A single flipped bit shows as exactly two edges on a steady line
	task automatic burst(input logic [7:0] d, input logic [7:0] e);
		toggles = 0;
		counting = 1'b1;
		wr(LCD_OFF_ERR_CTRL, d);
		idle(120);
		counting = 1'b0;
		check("tx toggles", 34'(toggles), 34'(e));
	endtask : burst
	task automatic conclude();
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude
	// ----
	// Main sequence
	// ----
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, counting, prev_out} = '0;
		{awaddr, araddr, wdata, mode, div, tx_clk, tx_in} = '0;
		wstrb = 4'h1;
		seed = 32'h4;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 34'h0);
		seed = xorshift(seed);
		tx_in <= seed[8];
		wr(LCD_OFF_LOOP_CTRL, {2'h0, seed[3:0], 2'h0});
		rd(LCD_OFF_LOOP_CTRL, 34'({2'h0, seed[3:0], 2'h0}));
		// Lane 0 strobe low: the write must leave the register alone
		wstrb <= 4'h0;
		wr(LCD_OFF_LOOP_CTRL, 8'hff);
		wstrb <= 4'h1;
		rd(LCD_OFF_LOOP_CTRL, 34'({2'h0, seed[3:0], 2'h0}));
		wr(LCD_OFF_ERR_CTRL, 8'h01);
		rd(LCD_OFF_ERR_CTRL, 34'h1);
		rd(8'h14, {2'h2, 32'h0});
		wr(LCD_OFF_INT_MASK, 8'h08);
		mode <= 2'h2;
		wr(LCD_OFF_LOOP_CTRL, {LCD_SEL_UP, 6'h0});
		idle(400);
		rd(LCD_OFF_STATUS, 34'h0);
		mode <= 2'h1;
		idle(400);
		rd(LCD_OFF_STATUS, 34'h8);
		check("irq", 34'(irq), 34'h1);
		rd(LCD_OFF_INT_STATUS, 34'h8);
		wr(LCD_OFF_INT_STATUS, 8'h08);
		rd(LCD_OFF_INT_STATUS, 34'h0);
		check("irq", 34'(irq), 34'h0);
		wr(LCD_OFF_INT_MASK, 8'h00);
		mode <= 2'h0;
		idle(400);
		rd(LCD_OFF_STATUS, 34'h0);
		rd(LCD_OFF_INT_STATUS, 34'h8);
		check("irq", 34'(irq), 34'h0);
		wr(LCD_OFF_INT_STATUS, 8'h08);
		mode <= 2'h2;
		wr(LCD_OFF_LOOP_CTRL, {LCD_SEL_DOWN, 6'h0});
		rd(LCD_OFF_STATUS, 34'h0);
		idle(400);
		rd(LCD_OFF_STATUS, 34'h8);
		mode <= 2'h1;
		wr(LCD_OFF_LOOP_CTRL, {LCD_SEL_AUTO, 6'h0});
		idle(400);
		rd(LCD_OFF_STATUS, 34'h9);
		check("loopback", 34'(loopback), 34'h1);
		wr(LCD_OFF_LOOP_CTRL, {LCD_SEL_OFF, 6'h0});
		rd(LCD_OFF_STATUS, 34'h0);
		check("loopback", 34'(loopback), 34'h0);
		wr(LCD_OFF_ERR_CTRL, 8'h10);
		idle(120);
		burst(8'h12, 8'h2);
		burst(8'h12, 8'h0);
		wr(LCD_OFF_ERR_CTRL, 8'h00);
		burst(8'h02, 8'h0);
		conclude();
	end
endmodule : lcd_loop_code_test
